// ==== logic/receiver_mode_profile_bank.sv ====
/*
  Byte-wide storage for receiver profiles 3 to 6 and the drive of the receive
  chain controls from the selected profile.
  Assumes the serial control port front end presents each decoded register access
  as a one-cycle read or write strobe with address and data on clk_sys.
*/
`default_nettype none
// Contract
// R1 - Profile 3 keeps channel 3 gain in bits 6:4 and channel 4 gain in bits 2:0 of one byte, both resetting to seven.
// R2 - Profile 4 keeps splitter enables in bits 6, 5, 4 resetting to one, zero and one.
// R3 - Profile 4 keeps channel 1 to 4 on bits in bits 3:0 with only channel 4 set after reset.
// R4 - Profile 4 keeps channel 1 gain in bits 6:4 and channel 2 gain in bits 2:0, both resetting to seven.
// R5 - Profile 4 keeps channel 3 gain in bits 6:4 and channel 4 gain in bits 2:0, both resetting to seven.
// R6 - Profile 5 resets all three writable splitter enables in bits 6:4 to one.
// R7 - Profile 5 resets all four channel on bits in bits 3:0 to one.
// R8 - Profile 5 keeps writable channel 1 and 2 gains in bits 6:4 and 2:0, both resetting to seven.
// R9 - Profile 5 keeps writable channel 3 and 4 gains in bits 6:4 and 2:0, both resetting to seven.
// R10 - Profile 6 resets the splitters to first on, pair A on and pair B off, all writable.
// R11 - Profile 6 resets channel 1 on and channels 2 to 4 off.
// R12 - Bit 7 of every register and bit 3 of every gain register read as zero and ignore writes.
// R13 - The receive chain controls follow the fields of the currently selected profile.
module receiver_mode_profile_bank (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [3:0] profile_sel,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            profile_hit,
  output logic            first_splitter_on,
  output logic            pair_a_splitter_on,
  output logic            pair_b_splitter_on,
  output logic      [3:0] path_on,
  output logic      [2:0] path1_gain,
  output logic      [2:0] path2_gain,
  output logic      [2:0] path3_gain,
  output logic      [2:0] path4_gain
);
  // ==========================================================================
  // Helpers.
  function automatic logic addr_hits(input logic [9:0] addr, input int unsigned idx);
    addr_hits = (addr == profile_bank_pkg::REG_OFFSET[idx]);
  endfunction

  function automatic logic [2:0] gain_hi(input logic [7:0] b);
    gain_hi = b[profile_bank_pkg::GAIN_HI_LSB +: profile_bank_pkg::GAIN_W];
  endfunction

  function automatic logic [2:0] gain_lo(input logic [7:0] b);
    gain_lo = b[profile_bank_pkg::GAIN_LO_LSB +: profile_bank_pkg::GAIN_W];
  endfunction

  // ==========================================================================
  // Storage.
  logic [7:0] bank [0:7];

  // One cell per register keeps each reset value and mask beside the field it serves.
  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_GAIN_B_SET3), // R1
    .WRITE_MASK  (profile_bank_pkg::GAIN_MASK)        // R12
  ) gain_b_set3_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_GAIN_B_SET3)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_GAIN_B_SET3])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_ENABLE_SET4), // R2 R3
    .WRITE_MASK  (profile_bank_pkg::ENABLE_MASK)      // R12
  ) enable_set4_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_ENABLE_SET4)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_ENABLE_SET4])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_GAIN_A_SET4), // R4
    .WRITE_MASK  (profile_bank_pkg::GAIN_MASK)        // R12
  ) gain_a_set4_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_GAIN_A_SET4)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_GAIN_A_SET4])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_GAIN_B_SET4), // R5
    .WRITE_MASK  (profile_bank_pkg::GAIN_MASK)        // R12
  ) gain_b_set4_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_GAIN_B_SET4)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_GAIN_B_SET4])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_ENABLE_SET5), // R6 R7
    .WRITE_MASK  (profile_bank_pkg::ENABLE_MASK)      // R12
  ) enable_set5_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_ENABLE_SET5)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_ENABLE_SET5])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_GAIN_A_SET5), // R8
    .WRITE_MASK  (profile_bank_pkg::GAIN_MASK)        // R12
  ) gain_a_set5_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_GAIN_A_SET5)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_GAIN_A_SET5])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_GAIN_B_SET5), // R9
    .WRITE_MASK  (profile_bank_pkg::GAIN_MASK)        // R12
  ) gain_b_set5_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_GAIN_B_SET5)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_GAIN_B_SET5])
  );

  profile_byte_cell #(
    .RESET_VALUE (profile_bank_pkg::RST_ENABLE_SET6), // R10 R11
    .WRITE_MASK  (profile_bank_pkg::ENABLE_MASK)      // R12
  ) enable_set6_cell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr && addr_hits(reg_addr, profile_bank_pkg::IDX_ENABLE_SET6)),
    .wr_data (reg_wdata),
    .value   (bank[profile_bank_pkg::IDX_ENABLE_SET6])
  );

  // ==========================================================================
  // Registered outputs.
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       hit;
    logic       split_first;
    logic       split_a;
    logic       split_b;
    logic [3:0] path_on;
    logic [2:0] gain1;
    logic [2:0] gain2;
    logic [2:0] gain3;
    logic [2:0] gain4;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  always_comb begin
    logic [7:0] en_byte;
    en_byte = 8'h00;
    state_next        = state_reg;
    state_next.rvalid = reg_rd;
    state_next.rdata  = profile_bank_pkg::READ_ZERO;
    for (int unsigned i = 0; i < profile_bank_pkg::REG_NUM; i++) begin
      if (reg_rd && addr_hits(reg_addr, i)) begin
        state_next.rdata = bank[i];
      end
    end
    // Fields that this bank does not hold drive zero, so an unlisted profile parks the chain off.
    state_next.hit   = 1'b0;
    state_next.gain1 = 3'h0;
    state_next.gain2 = 3'h0;
    state_next.gain3 = 3'h0;
    state_next.gain4 = 3'h0;
    unique case (profile_sel)
      profile_bank_pkg::PROFILE_3: begin
        state_next.hit   = 1'b1;
        state_next.gain3 = gain_hi(bank[profile_bank_pkg::IDX_GAIN_B_SET3]); // R13
        state_next.gain4 = gain_lo(bank[profile_bank_pkg::IDX_GAIN_B_SET3]);
      end
      profile_bank_pkg::PROFILE_4: begin
        state_next.hit   = 1'b1;
        en_byte          = bank[profile_bank_pkg::IDX_ENABLE_SET4]; // R13
        state_next.gain1 = gain_hi(bank[profile_bank_pkg::IDX_GAIN_A_SET4]);
        state_next.gain2 = gain_lo(bank[profile_bank_pkg::IDX_GAIN_A_SET4]);
        state_next.gain3 = gain_hi(bank[profile_bank_pkg::IDX_GAIN_B_SET4]);
        state_next.gain4 = gain_lo(bank[profile_bank_pkg::IDX_GAIN_B_SET4]);
      end
      profile_bank_pkg::PROFILE_5: begin
        state_next.hit   = 1'b1;
        en_byte          = bank[profile_bank_pkg::IDX_ENABLE_SET5]; // R13
        state_next.gain1 = gain_hi(bank[profile_bank_pkg::IDX_GAIN_A_SET5]);
        state_next.gain2 = gain_lo(bank[profile_bank_pkg::IDX_GAIN_A_SET5]);
        state_next.gain3 = gain_hi(bank[profile_bank_pkg::IDX_GAIN_B_SET5]);
        state_next.gain4 = gain_lo(bank[profile_bank_pkg::IDX_GAIN_B_SET5]);
      end
      profile_bank_pkg::PROFILE_6: begin
        state_next.hit = 1'b1;
        en_byte        = bank[profile_bank_pkg::IDX_ENABLE_SET6]; // R13
      end
      default: begin
        en_byte = 8'h00;
      end
    endcase
    state_next.split_first = en_byte[profile_bank_pkg::SPLIT_FIRST_BIT];
    state_next.split_a     = en_byte[profile_bank_pkg::SPLIT_PAIR_A_BIT];
    state_next.split_b     = en_byte[profile_bank_pkg::SPLIT_PAIR_B_BIT];
    state_next.path_on     = en_byte[profile_bank_pkg::PATH_ON_LSB +: profile_bank_pkg::PATH_ON_W];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata          = state_reg.rdata;
  assign reg_rvalid         = state_reg.rvalid;
  assign profile_hit        = state_reg.hit;
  assign first_splitter_on  = state_reg.split_first;
  assign pair_a_splitter_on = state_reg.split_a;
  assign pair_b_splitter_on = state_reg.split_b;
  assign path_on            = state_reg.path_on;
  assign path1_gain         = state_reg.gain1;
  assign path2_gain         = state_reg.gain2;
  assign path3_gain         = state_reg.gain3;
  assign path4_gain         = state_reg.gain4;
endmodule
`default_nettype wire

// ==== logic/profile_bank_pkg.sv ====
/*
  Constants for the receiver profile bank: register offsets, field positions,
  reset values, writable masks and profile numbers.
  Assumes a byte-wide register port that carries decoded serial-port accesses.
*/
`default_nettype none
package profile_bank_pkg;
  // ==========================================================================
  // Register port geometry.
  localparam int unsigned ADDR_W  = 10;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned REG_NUM = 8;

  // ==========================================================================
  // Register offsets.
  localparam logic [9:0] RECEIVE_GAIN_PAIR_B_SET3 = 10'h04B;
  localparam logic [9:0] RECEIVE_ENABLE_SET4      = 10'h04C;
  localparam logic [9:0] RECEIVE_GAIN_PAIR_A_SET4 = 10'h04D;
  localparam logic [9:0] RECEIVE_GAIN_PAIR_B_SET4 = 10'h04E;
  localparam logic [9:0] RECEIVE_ENABLE_SET5      = 10'h04F;
  localparam logic [9:0] RECEIVE_GAIN_PAIR_A_SET5 = 10'h050;
  localparam logic [9:0] RECEIVE_GAIN_PAIR_B_SET5 = 10'h051;
  localparam logic [9:0] RECEIVE_ENABLE_SET6      = 10'h052;

  localparam logic [9:0] REG_OFFSET [0:7] = '{
    RECEIVE_GAIN_PAIR_B_SET3, RECEIVE_ENABLE_SET4, RECEIVE_GAIN_PAIR_A_SET4, RECEIVE_GAIN_PAIR_B_SET4,
    RECEIVE_ENABLE_SET5, RECEIVE_GAIN_PAIR_A_SET5, RECEIVE_GAIN_PAIR_B_SET5, RECEIVE_ENABLE_SET6};

  // ==========================================================================
  // Register indices into the bank.
  localparam int unsigned IDX_GAIN_B_SET3 = 0;
  localparam int unsigned IDX_ENABLE_SET4 = 1;
  localparam int unsigned IDX_GAIN_A_SET4 = 2;
  localparam int unsigned IDX_GAIN_B_SET4 = 3;
  localparam int unsigned IDX_ENABLE_SET5 = 4;
  localparam int unsigned IDX_GAIN_A_SET5 = 5;
  localparam int unsigned IDX_GAIN_B_SET5 = 6;
  localparam int unsigned IDX_ENABLE_SET6 = 7;

  // ==========================================================================
  // Field positions.
  localparam int unsigned GAIN_HI_LSB      = 4;
  localparam int unsigned GAIN_LO_LSB      = 0;
  localparam int unsigned GAIN_W           = 3;
  localparam int unsigned SPLIT_FIRST_BIT  = 6;
  localparam int unsigned SPLIT_PAIR_A_BIT = 5;
  localparam int unsigned SPLIT_PAIR_B_BIT = 4;
  localparam int unsigned PATH_ON_LSB      = 0;
  localparam int unsigned PATH_ON_W        = 4;

  // ==========================================================================
  // Writable masks; masked-out bits are reserved and read as zero.
  localparam logic [7:0] GAIN_MASK   = 8'h77;
  localparam logic [7:0] ENABLE_MASK = 8'h7F;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_GAIN_B_SET3 = 8'h77;
  localparam logic [7:0] RST_ENABLE_SET4 = 8'h51;
  localparam logic [7:0] RST_GAIN_A_SET4 = 8'h77;
  localparam logic [7:0] RST_GAIN_B_SET4 = 8'h77;
  localparam logic [7:0] RST_ENABLE_SET5 = 8'h7F;
  localparam logic [7:0] RST_GAIN_A_SET5 = 8'h77;
  localparam logic [7:0] RST_GAIN_B_SET5 = 8'h77;
  localparam logic [7:0] RST_ENABLE_SET6 = 8'h68;

  localparam logic [7:0] REG_RESET [0:7] = '{
    RST_GAIN_B_SET3, RST_ENABLE_SET4, RST_GAIN_A_SET4, RST_GAIN_B_SET4,
    RST_ENABLE_SET5, RST_GAIN_A_SET5, RST_GAIN_B_SET5, RST_ENABLE_SET6};
  localparam logic [7:0] REG_MASK [0:7] = '{
    GAIN_MASK, ENABLE_MASK, GAIN_MASK, GAIN_MASK, ENABLE_MASK, GAIN_MASK, GAIN_MASK, ENABLE_MASK};

  // ==========================================================================
  // Profile numbers on the selector.
  localparam int unsigned SEL_W = 4;
  localparam logic [3:0] PROFILE_3 = 4'h3;
  localparam logic [3:0] PROFILE_4 = 4'h4;
  localparam logic [3:0] PROFILE_5 = 4'h5;
  localparam logic [3:0] PROFILE_6 = 4'h6;

  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage
`default_nettype wire

// ==== logic/profile_byte_cell.sv ====
/*
  One byte of profile storage with a fixed reset value and a writable mask.
  Assumes a single clock and a synchronous active-low reset.
*/
`default_nettype none
module profile_byte_cell #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value
);
  // ==========================================================================
  // State.
  typedef struct packed {
    logic [7:0] value;
  } cell_state_t;

  cell_state_t state_reg;
  cell_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      // Reserved bits are never stored, so they cannot read back as one.
      state_next.value = wr_data & WRITE_MASK; // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg.value <= RESET_VALUE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.value;
endmodule
`default_nettype wire

// ==== bench/profile_bank_properties.sv ====
/*
  Port-level assertions for the receiver profile bank.
  Assumes one clock, clk_sys, and a synchronous active-low reset, rst_n.
*/
`default_nettype none
module profile_bank_properties (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [3:0] profile_sel,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       profile_hit,
  input wire logic       first_splitter_on,
  input wire logic       pair_a_splitter_on,
  input wire logic       pair_b_splitter_on,
  input wire logic [3:0] path_on,
  input wire logic [2:0] path1_gain,
  input wire logic [2:0] path2_gain,
  input wire logic [2:0] path3_gain,
  input wire logic [2:0] path4_gain
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Register port.
  sequence enable5_write;
    reg_wr && !reg_rd && reg_addr == 10'h04F;
  endsequence
  sequence enable5_read;
    reg_rd && !reg_wr && reg_addr == 10'h04F;
  endsequence
  rvalid_follows_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read strobe");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  top_bit_zero_a: assert property (reg_rvalid |-> !reg_rdata[7])
    else $error("bit 7 read as one");
  gain_gap_zero_a: assert property (reg_rvalid && $past(reg_addr) inside {10'h04B, 10'h04D, 10'h04E, 10'h050,
    10'h051} |-> !reg_rdata[3]) else $error("gain bit 3 read as one");
  enable5_echo_a: assert property (enable5_write ##1 enable5_read |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7F))
    else $error("profile 5 enables not read back");
  // ==========================================================================
  // Receive chain controls; outputs lag the selector by one edge.
  hit_decode_a: assert property ($past(rst_n) |-> profile_hit == ($past(profile_sel) inside {[4'h3:4'h6]}))
    else $error("profile hit wrong");
  idle_controls_a: assert property ($past(rst_n) && !profile_hit |-> {first_splitter_on, pair_a_splitter_on,
    pair_b_splitter_on, path_on, path1_gain, path2_gain, path3_gain, path4_gain} == 19'h0)
    else $error("controls driven for a foreign profile");
endmodule

bind receiver_mode_profile_bank profile_bank_properties profile_bank_properties_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .profile_sel(profile_sel), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .profile_hit(profile_hit), .first_splitter_on(first_splitter_on), .pair_a_splitter_on(pair_a_splitter_on),
  .pair_b_splitter_on(pair_b_splitter_on), .path_on(path_on), .path1_gain(path1_gain),
  .path2_gain(path2_gain), .path3_gain(path3_gain), .path4_gain(path4_gain));
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the receiver profile bank.
  Assumes the bank alone, driven through its decoded register strobes.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals.
  logic       clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, profile_hit;
  logic       first_splitter_on, pair_a_splitter_on, pair_b_splitter_on;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] profile_sel, path_on;
  logic [2:0] path1_gain, path2_gain, path3_gain, path4_gain;
  int         err_count, check_count;
  logic [7:0] reset_image [8] = '{8'h77, 8'h51, 8'h77, 8'h77, 8'h7F, 8'h77, 8'h77, 8'h68};

  receiver_mode_profile_bank receiver_mode_profile_bank_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .profile_sel(profile_sel), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .profile_hit(profile_hit), .first_splitter_on(first_splitter_on), .pair_a_splitter_on(pair_a_splitter_on),
    .pair_b_splitter_on(pair_b_splitter_on), .path_on(path_on), .path1_gain(path1_gain),
    .path2_gain(path2_gain), .path3_gain(path3_gain), .path4_gain(path4_gain));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Tasks; wr, rd and ctrl are each entered just after a rising edge and return on one.
  task automatic conclude();
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    // A write right behind another lets one edge pass, so the strobe is never driven twice in one step.
    if (reg_wr) begin
      @(posedge clk_sys);
    end
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(20'({reg_rvalid, reg_rdata}), 20'({1'b1, exp}));
    @(posedge clk_sys);
  endtask
  // Controls settle one edge after the selector changes and one edge after a stored byte changes.
  task automatic ctrl(input logic [3:0] sel, input logic [19:0] exp);
    profile_sel <= sel;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({profile_hit, first_splitter_on, pair_a_splitter_on, pair_b_splitter_on, path_on, path1_gain,
      path2_gain, path3_gain, path4_gain}, exp);
    @(posedge clk_sys);
  endtask
  task automatic reset_bank();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  // ==========================================================================
  // Tests.
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, err_count, check_count} = '0;
    profile_sel = 4'h4;
    reset_bank();
    for (int i = 0; i < 8; i++) begin
      rd(10'h04B + 10'(i), reset_image[i]);
    end
    ctrl(4'h4, 20'hD1FFF);
    // Writing all ones exposes any reserved bit that wrongly stores.
    for (int i = 0; i < 8; i++) begin
      wr(10'h04B + 10'(i), 8'hFF);
      rd(10'h04B + 10'(i), (i % 3 == 1) ? 8'h7F : 8'h77);
      wr(10'h04B + 10'(i), 8'h00);
      rd(10'h04B + 10'(i), 8'h00);
    end
    wr(10'h053, 8'h5A);
    rd(10'h053, 8'h00);
    rd(10'h04A, 8'h00);
    rd(10'h052, 8'h00);
    wr(10'h04F, 8'h2A);
    wr(10'h050, 8'h35);
    wr(10'h051, 8'h61);
    wr(10'h052, 8'h45);
    wr(10'h04B, 8'h42);
    ctrl(4'h5, 20'hAA771);
    ctrl(4'h6, 20'hC5000);
    ctrl(4'h3, 20'h80022);
    ctrl(4'h9, 20'h00000);
    reset_bank();
    rd(10'h04F, 8'h7F);
    rd(10'h052, 8'h68);
    conclude();
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
